// ### rtl/pdc_defines.vh
// constants for the clock generator configuration decode and post dividers
//
// Behaviour
// - each loop keeps an 8-bit reference divide value at bits 7-0, 31-24, 55-48 (loop C set 1) and 79-72 (loop C set 2), and loop C uses set 2 while the set-select pin is high.
// - loops A and B keep an 11-bit feedback divide at bits 18-8 and 42-32, low three bits auxiliary count, upper eight bits main count.
// - loop C takes its feedback divide from bits 66-56 with the pin low and 90-80 with it high, split the same way.
// - outputs A and B take post-divide codes from bits 99-96 and 103-100, regardless of the pin.
// - output C takes its post-divide code from bits 107-104 with the pin low and 115-112 with it high.
// - output D takes its post-divide code from bits 111-108 with the pin low and 119-116 with it high.
// - post-divide codes 0 to 15 divide by 1,2,3,4,5,6,8,9,10,12,15,16,18,20,25,50.
// - the filter time-constant bit of each loop (20, 44, 68, 92) means short at 0 and long at 1.
// - the pump current bit of each loop (19, 43, 67, 91) means low at 0 and high at 1, loop C following the pin.
// - the whole configuration image reads zero after reset, so every divider starts at its zero setting.
// - each 2-bit source selector routes reference, loop A, loop B, loop C for codes 00, 01, 10, 11.
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH

// ----------------------------------------------------------------
// AXI4-Lite register map (byte offsets), four image words then status
// ----------------------------------------------------------------
`define PDC_OFS_IMAGE0 12'h000
`define PDC_OFS_IMAGE1 12'h004
`define PDC_OFS_IMAGE2 12'h008
`define PDC_OFS_IMAGE3 12'h00C
`define PDC_OFS_STATUS 12'h010
`define PDC_IMAGE_RESET 128'h0000_0000_0000_0000_0000_0000_0000_0000
`define PDC_RESP_OKAY 2'b00
`define PDC_RESP_SLVERR 2'b10

// ----------------------------------------------------------------
// image field positions
// ----------------------------------------------------------------
`define PDC_REF_A 7:0
`define PDC_REF_B 31:24
`define PDC_REF_C1 55:48
`define PDC_REF_C2 79:72
`define PDC_FB_A 18:8
`define PDC_FB_B 42:32
`define PDC_FB_C1 66:56
`define PDC_FB_C2 90:80
`define PDC_PUMP_A 19
`define PDC_PUMP_B 43
`define PDC_PUMP_C1 67
`define PDC_PUMP_C2 91
`define PDC_TC_A 20
`define PDC_TC_B 44
`define PDC_TC_C1 68
`define PDC_TC_C2 92
`define PDC_MUX_A 23:22
`define PDC_MUX_B 47:46
`define PDC_MUX_C1 71:70
`define PDC_MUX_D1 95:94
`define PDC_MUX_C2 125:124
`define PDC_MUX_D2 127:126
`define PDC_POST_A 99:96
`define PDC_POST_B 103:100
`define PDC_OUT_DIVIDE_C_SET1 107:104
`define PDC_OUT_DIVIDE_D_SET1 111:108
`define PDC_OUT_DIVIDE_C_SET2 115:112
`define PDC_OUT_DIVIDE_D_SET2 119:116
`define PDC_FB_AUX 2:0
`define PDC_FB_MAIN 10:3

`endif

// ### rtl/pdc_post_divider.v
// integer post divider with sixteen selectable ratios
`timescale 1ns/10ps
module pdc_post_divider (
    input wire aclk,          // system clock
    input wire aresetn,       // synchronous reset, active low
    input wire clk_en_in,     // source clock as a sampled level
    input wire [3:0] code,    // post-divide code
    output reg clk_out,       // divided clock level
    output reg [5:0] ratio    // decoded ratio, registered
);
    reg [3:0] code_q;
    reg [5:0] count;
    reg in_q;
    wire rise;
    wire [5:0] r;

    // ratio lookup shared by the reload and the status view
    function [5:0] pdc_ratio;
        input [3:0] c;
        begin
            case (c)
                4'h0: pdc_ratio = 6'd1;
                4'h1: pdc_ratio = 6'd2;
                4'h2: pdc_ratio = 6'd3;
                4'h3: pdc_ratio = 6'd4;
                4'h4: pdc_ratio = 6'd5;
                4'h5: pdc_ratio = 6'd6;
                4'h6: pdc_ratio = 6'd8;
                4'h7: pdc_ratio = 6'd9;
                4'h8: pdc_ratio = 6'd10;
                4'h9: pdc_ratio = 6'd12;
                4'hA: pdc_ratio = 6'd15;
                4'hB: pdc_ratio = 6'd16;
                4'hC: pdc_ratio = 6'd18;
                4'hD: pdc_ratio = 6'd20;
                4'hE: pdc_ratio = 6'd25;
                default: pdc_ratio = 6'd50;
            endcase
        end
    endfunction

    assign r = pdc_ratio(code);
    assign rise = clk_en_in & ~in_q;

    // count source rising edges; output high for the first half period
    always @(posedge aclk) begin
        if (!aresetn) begin
            code_q <= 4'h0;
            count <= 6'd0;
            in_q <= 1'b0;
            clk_out <= 1'b0;
            ratio <= 6'd1;
        end else begin
            in_q <= clk_en_in;
            code_q <= code;
            ratio <= r;
            if (code != code_q) begin
                count <= 6'd0;
            end else if (rise) begin
                if (count >= r - 6'd1) begin
                    count <= 6'd0;
                end else begin
                    count <= count + 6'd1;
                end
            end
            // ratio 1 follows the source; others low once half is spent
            if (r == 6'd1) begin
                clk_out <= clk_en_in;
            end else if (rise) begin
                clk_out <= (count >= r - 6'd1) ||
                    (count < (r >> 1) - 6'd1);
            end
        end
    end
endmodule // pdc_post_divider

// ### rtl/pdc_config_select.v
// configuration image, AXI4-Lite slave, set select and four post dividers
`timescale 1ns/10ps
`include "pdc_defines.vh"
module pdc_config_select (
    input wire aclk,                 // system clock, 125 MHz
    input wire aresetn,              // synchronous reset, active low
    input wire [11:0] s_axi_awaddr,  // write address
    input wire s_axi_awvalid,        // write address valid
    output wire s_axi_awready,       // write address ready
    input wire [31:0] s_axi_wdata,   // write data
    input wire [3:0] s_axi_wstrb,    // write byte strobes
    input wire s_axi_wvalid,         // write data valid
    output wire s_axi_wready,        // write data ready
    output reg [1:0] s_axi_bresp,    // write response
    output reg s_axi_bvalid,         // write response valid
    input wire s_axi_bready,         // write response ready
    input wire [11:0] s_axi_araddr,  // read address
    input wire s_axi_arvalid,        // read address valid
    output wire s_axi_arready,       // read address ready
    output reg [31:0] s_axi_rdata,   // read data
    output reg [1:0] s_axi_rresp,    // read response
    output reg s_axi_rvalid,         // read data valid
    input wire s_axi_rready,         // read data ready
    input wire set_select_pin,       // picks loop C / outputs C,D set 2
    input wire ref_clk,              // reference clock level
    input wire loop_a_clk,           // loop A clock level
    input wire loop_b_clk,           // loop B clock level
    input wire loop_c_clk,           // loop C clock level
    output reg [7:0] ref_divide_a,   // loop A reference divide
    output reg [7:0] ref_divide_b,   // loop B reference divide
    output reg [7:0] ref_divide_c,   // loop C reference divide, selected
    output reg [2:0] aux_count_a,    // loop A auxiliary counter
    output reg [7:0] main_count_a,   // loop A main counter
    output reg [2:0] aux_count_b,    // loop B auxiliary counter
    output reg [7:0] main_count_b,   // loop B main counter
    output reg [2:0] aux_count_c,    // loop C auxiliary counter, selected
    output reg [7:0] main_count_c,   // loop C main counter, selected
    output reg [2:0] filter_long,    // loop filter long constant, C..A
    output reg [2:0] pump_high,      // charge pump high current, C..A
    output wire clk_out_a,           // output clock A
    output wire clk_out_b,           // output clock B
    output wire clk_out_c,           // output clock C
    output wire clk_out_d            // output clock D
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    reg [127:0] image;
    reg aw_held, w_held;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg sel_q;
    reg [3:0] src_q;
    wire [5:0] ratio_a, ratio_b, ratio_c, ratio_d;
    wire [3:0] post_c, post_d;
    wire [1:0] mux_c, mux_d;
    wire do_write;

    // merge one word into the image under byte strobes
    function [31:0] pdc_merge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0] stb;
        integer i;
        begin
            pdc_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (stb[i]) begin
                    pdc_merge[i*8 +: 8] = dat[i*8 +: 8];
                end
            end
        end
    endfunction

    // source multiplexer ahead of each post divider
    function pdc_route;
        input [1:0] sel;
        input [3:0] src;
        begin
            pdc_route = src[sel];
        end
    endfunction

    // ------------------------------------------------------------
    // AXI4-Lite write: address and data caught in either order
    // ------------------------------------------------------------
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign do_write = aw_held & w_held & ~s_axi_bvalid;

    // one outstanding write; response issued the cycle after both held
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PDC_RESP_OKAY;
            image <= `PDC_IMAGE_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `PDC_RESP_OKAY;
                if (aw_addr == `PDC_OFS_IMAGE0) begin
                    image[31:0] <= pdc_merge(image[31:0], w_data, w_strb);
                end else if (aw_addr == `PDC_OFS_IMAGE1) begin
                    image[63:32] <= pdc_merge(image[63:32], w_data, w_strb);
                end else if (aw_addr == `PDC_OFS_IMAGE2) begin
                    image[95:64] <= pdc_merge(image[95:64], w_data, w_strb);
                end else if (aw_addr == `PDC_OFS_IMAGE3) begin
                    image[127:96] <= pdc_merge(image[127:96], w_data,
                        w_strb);
                end else if (aw_addr != `PDC_OFS_STATUS) begin
                    s_axi_bresp <= `PDC_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read: data registered one cycle after the address
    // ------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;

    // status word shows the pin and the live ratios of A, B, C and D
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PDC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `PDC_RESP_OKAY;
            if (s_axi_araddr == `PDC_OFS_IMAGE0) begin
                s_axi_rdata <= image[31:0];
            end else if (s_axi_araddr == `PDC_OFS_IMAGE1) begin
                s_axi_rdata <= image[63:32];
            end else if (s_axi_araddr == `PDC_OFS_IMAGE2) begin
                s_axi_rdata <= image[95:64];
            end else if (s_axi_araddr == `PDC_OFS_IMAGE3) begin
                s_axi_rdata <= image[127:96];
            end else if (s_axi_araddr == `PDC_OFS_STATUS) begin
                s_axi_rdata <= {1'b0, sel_q, ratio_d, 2'b00, ratio_c,
                    2'b00, ratio_b, 2'b00, ratio_a};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `PDC_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // loop settings decode, registered
    // ------------------------------------------------------------
    // the pin is a plain level; loop C settings swap on its change
    always @(posedge aclk) begin
        if (!aresetn) begin
            sel_q <= 1'b0;
            ref_divide_a <= 8'h00;
            ref_divide_b <= 8'h00;
            ref_divide_c <= 8'h00;
            aux_count_a <= 3'h0;
            main_count_a <= 8'h00;
            aux_count_b <= 3'h0;
            main_count_b <= 8'h00;
            aux_count_c <= 3'h0;
            main_count_c <= 8'h00;
            filter_long <= 3'h0;
            pump_high <= 3'h0;
        end else begin
            sel_q <= set_select_pin;
            ref_divide_a <= image[`PDC_REF_A];
            ref_divide_b <= image[`PDC_REF_B];
            ref_divide_c <= set_select_pin ? image[`PDC_REF_C2] :
                image[`PDC_REF_C1];
            aux_count_a <= image[10:8];
            main_count_a <= image[18:11];
            aux_count_b <= image[34:32];
            main_count_b <= image[42:35];
            aux_count_c <= set_select_pin ? image[82:80] :
                image[58:56];
            main_count_c <= set_select_pin ? image[90:83] :
                image[66:59];
            filter_long <= {set_select_pin ? image[`PDC_TC_C2] :
                image[`PDC_TC_C1], image[`PDC_TC_B],
                image[`PDC_TC_A]};
            pump_high <= {set_select_pin ? image[`PDC_PUMP_C2] :
                image[`PDC_PUMP_C1], image[`PDC_PUMP_B],
                image[`PDC_PUMP_A]};
        end
    end

    // ------------------------------------------------------------
    // output paths: source mux then post divider
    // ------------------------------------------------------------
    // sources sampled once so all four dividers see the same levels
    always @(posedge aclk) begin
        if (!aresetn) begin
            src_q <= 4'h0;
        end else begin
            src_q <= {loop_c_clk, loop_b_clk, loop_a_clk, ref_clk};
        end
    end

    // rewriting these while an output runs glitches it (host's duty)
    assign post_c = set_select_pin ? image[`PDC_OUT_DIVIDE_C_SET2] :
        image[`PDC_OUT_DIVIDE_C_SET1];
    assign post_d = set_select_pin ? image[`PDC_OUT_DIVIDE_D_SET2] :
        image[`PDC_OUT_DIVIDE_D_SET1];
    assign mux_c = set_select_pin ? image[`PDC_MUX_C2] : image[`PDC_MUX_C1];
    assign mux_d = set_select_pin ? image[`PDC_MUX_D2] : image[`PDC_MUX_D1];

    pdc_post_divider u_div_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en_in(pdc_route(image[`PDC_MUX_A], src_q)),
        .code(image[`PDC_POST_A]),
        .clk_out(clk_out_a),
        .ratio(ratio_a)
    );
    pdc_post_divider u_div_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en_in(pdc_route(image[`PDC_MUX_B], src_q)),
        .code(image[`PDC_POST_B]),
        .clk_out(clk_out_b),
        .ratio(ratio_b)
    );
    pdc_post_divider u_div_c (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en_in(pdc_route(mux_c, src_q)),
        .code(post_c),
        .clk_out(clk_out_c),
        .ratio(ratio_c)
    );
    pdc_post_divider u_div_d (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en_in(pdc_route(mux_d, src_q)),
        .code(post_d),
        .clk_out(clk_out_d),
        .ratio(ratio_d)
    );
endmodule // pdc_config_select

// ### tb/pdc_config_select_asserts.sv
// property checker for the configuration decode and register bus
`timescale 1ns/10ps
module pdc_config_select_asserts (
    input wire aclk, // system clock
    input wire aresetn, // synchronous reset, active low
    input wire s_axi_awvalid, // write address valid
    input wire s_axi_awready, // write address ready
    input wire s_axi_wvalid, // write data valid
    input wire s_axi_wready, // write data ready
    input wire [1:0] s_axi_bresp, // write response
    input wire s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire s_axi_arvalid, // read address valid
    input wire s_axi_arready, // read address ready
    input wire [31:0] s_axi_rdata, // read data
    input wire [1:0] s_axi_rresp, // read response
    input wire s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    input wire set_select_pin, // set select level
    input wire [7:0] ref_divide_a, // loop A reference divide
    input wire [7:0] ref_divide_b, // loop B reference divide
    input wire [7:0] ref_divide_c, // loop C reference divide
    input wire [2:0] aux_count_a, // loop A auxiliary count
    input wire [7:0] main_count_a, // loop A main count
    input wire [2:0] aux_count_b, // loop B auxiliary count
    input wire [7:0] main_count_b, // loop B main count
    input wire [2:0] aux_count_c, // loop C auxiliary count
    input wire [7:0] main_count_c, // loop C main count
    input wire [2:0] filter_long, // filter constants
    input wire [2:0] pump_high, // pump currents
    input wire clk_out_a, // output clock A
    input wire clk_out_b, // output clock B
    input wire clk_out_c, // output clock C
    input wire clk_out_d // output clock D
);
    // --------------------------------------------------------------
    // properties
    // --------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // all decoded settings as one vector, so a stray update shows anywhere
    wire [62:0] dec = {ref_divide_a, ref_divide_b, ref_divide_c,
        aux_count_a, main_count_a, aux_count_b, main_count_b,
        aux_count_c, main_count_c, filter_long, pump_high};

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response not two edges after handshake");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before accepted");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped before accepted");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read data not one edge after address");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_aw_refused: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_decode_steady: assert property (
        $stable(set_select_pin) && !$rose(s_axi_bvalid) |=> $stable(dec))
        else $error("decoded setting moved without a cause");
    a_reset_clear: assert property ($rose(aresetn) |->
        dec == 63'h0 && !s_axi_bvalid && !s_axi_rvalid &&
        {clk_out_a, clk_out_b, clk_out_c, clk_out_d} == 4'h0)
        else $error("outputs not cleared by reset");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_pin: cover property ($rose(set_select_pin));
endmodule // pdc_config_select_asserts

bind pdc_config_select pdc_config_select_asserts u_chk (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .set_select_pin, .ref_divide_a, .ref_divide_b,
    .ref_divide_c, .aux_count_a, .main_count_a, .aux_count_b,
    .main_count_b, .aux_count_c, .main_count_c, .filter_long, .pump_high,
    .clk_out_a, .clk_out_b, .clk_out_c, .clk_out_d);

// ### tb/tb_top.sv
// self-checking bench for the configuration decode and post dividers
`timescale 1ns/10ps
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic set_select_pin = 1'b0;
    logic [4:0] src_cnt = 5'h00;
    logic [3:0] src_d1 = 4'h0, src_d2 = 4'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, clk_out_a, clk_out_b, clk_out_c, clk_out_d;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0] ref_divide_a, ref_divide_b, ref_divide_c;
    wire [7:0] main_count_a, main_count_b, main_count_c;
    wire [2:0] aux_count_a, aux_count_b, aux_count_c, filter_long, pump_high;
    wire [3:0] src = src_cnt[4:1]; // loop C, loop B, loop A, reference
    int error_cnt = 0, comparisons = 0, i;
    logic [127:0] img;
    logic [3:0] c;
    logic [5:0] rtab [16] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 12, 15, 16, 18,
        20, 25, 50};

    pdc_config_select uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .set_select_pin,
        .ref_clk(src[0]), .loop_a_clk(src[1]), .loop_b_clk(src[2]),
        .loop_c_clk(src[3]), .ref_divide_a, .ref_divide_b, .ref_divide_c,
        .aux_count_a, .main_count_a, .aux_count_b, .main_count_b,
        .aux_count_c, .main_count_c, .filter_long, .pump_high, .clk_out_a,
        .clk_out_b, .clk_out_c, .clk_out_d);

    // --------------------------------------------------------------
    // clock, source levels and their two-edge history
    // --------------------------------------------------------------
    initial begin
        forever #4 aclk = ~aclk;
    end
    // sources are slow binary counter bits, all below half the clock rate
    always @(posedge aclk) begin
        src_cnt <= src_cnt + 5'h01;
        src_d1 <= src;
        src_d2 <= src_d1;
    end

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        if (error_cnt == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // address and data offered together, each dropped once taken
    task axi_write(input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // bready stays high; only the watchdog ends a missing answer
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        check(s_axi_bresp, er);
    endtask
    task axi_read(input logic [11:0] a, input logic [1:0] er,
        input logic [31:0] exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        check(s_axi_rresp, er);
        check(s_axi_rdata, exp);
    endtask
    // decode against the image, then outputs against their routed source;
    // only valid while every post code is zero (ratio 1)
    task chk_dec;
        logic p;
        // judge only after a rewrite or pin change has settled
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        p = set_select_pin;
        check(ref_divide_a, img[7:0]);
        check(ref_divide_b, img[31:24]);
        check(ref_divide_c, p ? img[79:72] : img[55:48]);
        check({main_count_a, aux_count_a}, img[18:8]);
        check({main_count_b, aux_count_b}, img[42:32]);
        check({main_count_c, aux_count_c}, p ? img[90:80] : img[66:56]);
        check(filter_long, {p ? img[92] : img[68], img[44], img[20]});
        check(pump_high, {p ? img[91] : img[67], img[43], img[19]});
        repeat (40) begin
            @(negedge aclk);
            check({clk_out_d, clk_out_c, clk_out_b, clk_out_a},
                {src_d2[p ? img[127:126] : img[95:94]],
                src_d2[p ? img[125:124] : img[71:70]],
                src_d2[img[47:46]], src_d2[img[23:22]]});
        end
    endtask

    // --------------------------------------------------------------
    // test sequence
    // --------------------------------------------------------------
    initial begin
        img = 128'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 4; i++) axi_read(12'(4 * i), 2'b00, 0);
        axi_read(12'h010, 2'b00, 32'h0101_0101);
        chk_dec;
        img = {32'hD000_0000, 32'h36B9_C2D5, 32'h7E4D_5A6C, 32'h5A9B_C3E1};
        for (i = 0; i < 4; i++) axi_write(12'(4 * i), img[32*i +: 32],
            4'hF, 2'b00);
        for (i = 0; i < 4; i++) axi_read(12'(4 * i), 2'b00, img[32*i +: 32]);
        chk_dec;
        set_select_pin <= 1'b1;
        chk_dec;
        // status writes are ignored, unmapped places answer with an error
        axi_write(12'h010, 32'hFFFF_FFFF, 4'hF, 2'b00);
        axi_write(12'h014, 32'hFFFF_FFFF, 4'hF, 2'b10);
        axi_read(12'h014, 2'b10, 0);
        axi_read(12'hFFC, 2'b10, 0);
        axi_read(12'h00C, 2'b00, 32'hD000_0000);
        axi_write(12'h000, 32'hFFFF_FF11, 4'h1, 2'b00);
        axi_read(12'h000, 2'b00, 32'h5A9B_C311);
        // every code on A and B, even codes on C and odd codes on D, pin flipping alongside the code
        for (i = 0; i < 16; i++) begin
            c = i[3:0];
            set_select_pin <= c[0];
            axi_write(12'h00C, {8'hD0, c, ~c, ~c, c, ~c, c}, 4'hF, 2'b00);
            repeat (3) @(posedge aclk);
            axi_read(12'h010, 2'b00, {1'b0, c[0],
                rtab[c[0] ? c : ~c], 2'b0, rtab[c[0] ? ~c : c], 2'b0,
                rtab[~c], 2'b0, rtab[c]});
        end
        set_select_pin <= 1'b0;
        repeat (3) @(posedge aclk);
        axi_read(12'h010, 2'b00, 32'h0132_0132);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(12'h00C, 2'b00, 0);
        axi_read(12'h010, 2'b00, 32'h0101_0101);
        stop_test;
    end

    // watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        stop_test;
    end
endmodule // tb_top
